// ==== rtl/mic_intc.v ====
// interrupt controller for an 8-bit core: arbitration, vectors, trap,
// return, external line sensing and wake-up selection.
// assumes pins and cpu strobes synchronous to CLK, AXI4-Lite master.
//
// Notes on behaviour
// - maskable requests served only with mask clear
// - masked requests stay pending until unmasked
// - global mask set out of reset
// - entry: finish instruction, push context, mask, vector
// - return pops context and clears mask
// - no nesting, entry sets mask
// - fixed priority, lowest number wins
// - any wakes wait; selected sources wake halt
// - trap entered regardless of mask
// - edge requests latched, cleared on handler entry
// - nand group low pin masks line request
// - peripheral request needs enable and clear mask
// - clear sequence discards pending latched request
// - two-byte vectors descending from top of memory
// - auto-wakeup only from wait and auto-wakeup halt mode
// - active-halt woken by timer overflow and rtc1
// - sense register: four 2-bit fields, reset zero
// - sense codes: fall+low, rise, fall, both
// - sense writes accepted only while masked
// - sense change clears line pending request
// - pin select reset 0Ch, line3 picks PB0-PB2
// - line2 picks PB3-PB6; PB4 no halt wake
// - line1 picks PA4-PA7, line0 PA0-PA3
`timescale 1ns/1ps
`include "mic_consts.vh"

module mic_intc (
	// clock and reset
	input  wire        CLK,
	input  wire        RST_N,
	// axi4-lite write address
	input  wire [31:0] S_AXI_AWADDR,
	input  wire        S_AXI_AWVALID,
	output wire        S_AXI_AWREADY,
	// axi4-lite write data
	input  wire [31:0] S_AXI_WDATA,
	input  wire [3:0]  S_AXI_WSTRB,
	input  wire        S_AXI_WVALID,
	output wire        S_AXI_WREADY,
	// axi4-lite write response
	output reg  [1:0]  S_AXI_BRESP,
	output reg         S_AXI_BVALID,
	input  wire        S_AXI_BREADY,
	// axi4-lite read address
	input  wire [31:0] S_AXI_ARADDR,
	input  wire        S_AXI_ARVALID,
	output wire        S_AXI_ARREADY,
	// axi4-lite read data
	output reg  [31:0] S_AXI_RDATA,
	output reg  [1:0]  S_AXI_RRESP,
	output reg         S_AXI_RVALID,
	input  wire        S_AXI_RREADY,
	// port pins feeding external lines
	input  wire [7:0]  PORT_A,
	input  wire [6:0]  PORT_B,
	input  wire [3:0]  EXT_NAND_EN,
	// peripheral request sources
	input  wire [13:0] PERIPH_FLAG,
	input  wire [13:0] PERIPH_EN,
	input  wire [13:0] PERIPH_CLR,
	// cpu sequencer
	input  wire        INSTR_END,
	input  wire        TRAP_EXEC,
	input  wire        RETURN_FROM_HANDLER_EXEC,
	input  wire        SET_MASK,
	input  wire        CLR_MASK,
	output wire        CPU_STALL,
	output reg         STACK_PUSH,
	output reg         STACK_POP,
	output reg  [1:0]  STACK_SEL,
	output reg         PC_LOAD,
	output reg  [15:0] VEC_ADDR,
	output reg         GLOBAL_MASK,
	// low power modes
	input  wire        MODE_WAIT,
	input  wire        MODE_HALT,
	input  wire        MODE_AUTO_WAKEUP_HALT_MODE,
	input  wire        MODE_ACTIVE_HALT,
	output reg         WAKE_UP
);

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	reg rst_ff1;
	reg rst_ff2;
	wire rst_n = rst_ff2;

	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_ff1 <= 1'b0;
			rst_ff2 <= 1'b0;
		end else begin
			rst_ff1 <= 1'b1;
			rst_ff2 <= rst_ff1;
		end
	end

	// ----------------------------------------
	// declarations
	// ----------------------------------------
	reg  [7:0]  sense;
	reg  [7:0]  pinsel;
	reg  [13:0] periph_pend;
	reg  [1:0]  state;
	reg  [1:0]  ctx_cnt;
	reg         trap_pend;
	reg         took_trap;
	reg  [3:0]  took_src;
	reg         aw_held;
	reg         w_held;
	reg  [31:0] aw_addr;
	reg  [7:0]  w_data;
	reg         w_lane0;
	wire [3:0]  ext_req;
	wire [3:0]  ext_halt_ok;
	reg  [3:0]  sel_src;
	reg         sel_any;
	reg  [31:0] next_rdata;
	reg  [1:0]  next_rresp;
	reg         next_wake;
	integer     k;
	wire [15:0] grp_all = {1'b1, PORT_B[2:0], PORT_B[6:3], PORT_A[7:4], PORT_A[3:0]};
	wire [13:0] req_all;
	wire        wr_fire = aw_held & w_held & ~S_AXI_BVALID;
	wire        wr_hit  = (aw_addr[`MIC_ADDR_HI] == 28'h000_0000);
	wire        sense_wr = wr_fire & wr_hit & w_lane0 & (aw_addr[`MIC_ADDR_LO] == `MIC_ADDR_SENSE)
	                       & GLOBAL_MASK;
	wire        pinsel_wr = wr_fire & wr_hit & w_lane0 & (aw_addr[`MIC_ADDR_LO] == `MIC_ADDR_PINSEL);
	wire        load_ext = (state == `MIC_ST_LOAD) & ~took_trap;
	wire        trap_now = trap_pend | TRAP_EXEC;
	wire        maskable_go = ~GLOBAL_MASK & sel_any;
	wire        entry_go = (state == `MIC_ST_IDLE) & INSTR_END & (trap_now | maskable_go);

	// ----------------------------------------
	// external lines
	// ----------------------------------------
	genvar i;
	generate
		for (i = 0; i < 4; i = i + 1) begin : g_line
			reg        prev;
			reg        latch;
			wire [1:0] code = sense[2*i+1:2*i];
			wire [3:0] grp  = grp_all[4*i+3:4*i];
			wire       src  = grp[pinsel[2*i+1:2*i]];
			wire       rise = src & ~prev;
			wire       fall = ~src & prev;
			wire       nand_ok = ~EXT_NAND_EN[i] | (&grp);
			wire       low_lvl = (code == `MIC_SENSE_FALL_LOW) & ~src;
			wire       chg = sense_wr & (w_data[2*i+1:2*i] != code);
			wire       ack = load_ext & (took_src == (`MIC_SRC_LINE0 + i));
			reg        hit;

			always @* begin
				case (code)
					`MIC_SENSE_FALL_LOW: hit = fall;
					`MIC_SENSE_RISE:     hit = rise;
					`MIC_SENSE_FALL:     hit = fall;
					default:             hit = rise | fall;
				endcase
			end

			// a new edge in the clearing cycle is kept
			always @(posedge CLK or negedge rst_n) begin
				if (!rst_n) begin
					prev  <= 1'b1;
					latch <= 1'b0;
				end else begin
					prev  <= src;
					latch <= (hit & nand_ok) | (latch & ~ack & ~chg);
				end
			end

			assign ext_req[i]     = (latch | low_lvl) & nand_ok;
			assign ext_halt_ok[i] = !((i == 2) && (pinsel[2*i+1:2*i] == `MIC_PINSEL_PB4));
		end
	endgenerate

	// ----------------------------------------
	// peripheral requests and arbitration
	// ----------------------------------------
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			periph_pend <= 14'h0000;
		else
			periph_pend <= PERIPH_FLAG | (periph_pend & ~PERIPH_CLR);
	end

	// line sources 1..4 replace peripheral slots; slot 13 is unused
	assign req_all = {1'b0, periph_pend[12:5] & PERIPH_EN[12:5], ext_req,
	                  periph_pend[0] & PERIPH_EN[0]};

	always @* begin
		sel_src = 4'h0;
		sel_any = 1'b0;
		for (k = `MIC_NSRC - 1; k >= 0; k = k - 1) begin
			if (req_all[k]) begin
				sel_src = k[3:0];
				sel_any = 1'b1;
			end
		end
	end

	// ----------------------------------------
	// entry and return sequencer
	// ----------------------------------------
	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			state       <= `MIC_ST_IDLE;
			ctx_cnt     <= 2'b00;
			trap_pend   <= 1'b0;
			took_trap   <= 1'b0;
			took_src    <= 4'h0;
			STACK_PUSH  <= 1'b0;
			STACK_POP   <= 1'b0;
			STACK_SEL   <= 2'b00;
			PC_LOAD     <= 1'b0;
			VEC_ADDR    <= `MIC_VEC_RESET;
			GLOBAL_MASK <= 1'b1;
		end else begin
			STACK_PUSH <= 1'b0;
			STACK_POP  <= 1'b0;
			PC_LOAD    <= 1'b0;
			if (TRAP_EXEC)
				trap_pend <= 1'b1;
			if (SET_MASK)
				GLOBAL_MASK <= 1'b1;
			else if (CLR_MASK)
				GLOBAL_MASK <= 1'b0;
			case (state)
				`MIC_ST_IDLE: begin
					if (entry_go) begin
						// trap is not maskable and outranks every source
						took_trap  <= trap_now;
						took_src   <= sel_src;
						trap_pend  <= 1'b0;
						ctx_cnt    <= 2'b00;
						STACK_PUSH <= 1'b1;
						STACK_SEL  <= 2'b00;
						state      <= `MIC_ST_PUSH;
					end else if (RETURN_FROM_HANDLER_EXEC) begin
						ctx_cnt   <= 2'b00;
						STACK_POP <= 1'b1;
						STACK_SEL <= `MIC_CTX_LAST;
						state     <= `MIC_ST_POP;
					end
				end
				`MIC_ST_PUSH: begin
					// order: pc, x, a, flags
					ctx_cnt    <= ctx_cnt + 2'b01;
					STACK_PUSH <= 1'b1;
					STACK_SEL  <= ctx_cnt + 2'b01;
					if (ctx_cnt == `MIC_CTX_LAST - 2'b01)
						state <= `MIC_ST_LOAD;
				end
				`MIC_ST_LOAD: begin
					GLOBAL_MASK <= 1'b1;
					PC_LOAD     <= 1'b1;
					VEC_ADDR    <= took_trap ? `MIC_VEC_TRAP
					               : (`MIC_VEC_SRC0 - {11'h000, took_src, 1'b0});
					state       <= `MIC_ST_IDLE;
				end
				default: begin
					// pops in reverse: flags, a, x, pc
					if (ctx_cnt == `MIC_CTX_LAST) begin
						GLOBAL_MASK <= 1'b0;
						state       <= `MIC_ST_IDLE;
					end else begin
						ctx_cnt   <= ctx_cnt + 2'b01;
						STACK_POP <= 1'b1;
						STACK_SEL <= `MIC_CTX_LAST - ctx_cnt - 2'b01;
					end
				end
			endcase
		end
	end

	assign CPU_STALL = (state != `MIC_ST_IDLE);

	// ----------------------------------------
	// wake-up selection
	// ----------------------------------------
	always @* begin
		next_wake = 1'b0;
		if (MODE_WAIT)
			next_wake = |req_all;
		else if (MODE_ACTIVE_HALT)
			next_wake = req_all[`MIC_SRC_ATOVF] | req_all[`MIC_SRC_LTRTC1];
		else if (MODE_HALT || MODE_AUTO_WAKEUP_HALT_MODE)
			next_wake = (|(ext_req & ext_halt_ok)) | req_all[`MIC_SRC_SPI]
			            | (MODE_AUTO_WAKEUP_HALT_MODE & req_all[`MIC_SRC_AWU]);
	end

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n)
			WAKE_UP <= 1'b0;
		else
			WAKE_UP <= next_wake;
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	assign S_AXI_AWREADY = ~aw_held & ~S_AXI_BVALID;
	assign S_AXI_WREADY  = ~w_held & ~S_AXI_BVALID;
	assign S_AXI_ARREADY = ~S_AXI_RVALID;

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			aw_held      <= 1'b0;
			w_held       <= 1'b0;
			aw_addr      <= 32'h0000_0000;
			w_data       <= 8'h00;
			w_lane0      <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP  <= `MIC_RESP_OKAY;
			sense        <= `MIC_SENSE_RST;
			pinsel       <= `MIC_PINSEL_RST;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_held <= 1'b1;
				aw_addr <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_held  <= 1'b1;
				w_data  <= S_AXI_WDATA[7:0];
				w_lane0 <= S_AXI_WSTRB[0];
			end
			if (wr_fire) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP  <= (wr_hit && aw_addr[1:0] == 2'b00) ? `MIC_RESP_OKAY : `MIC_RESP_SLVERR;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
			if (sense_wr)
				sense <= w_data;
			if (pinsel_wr)
				pinsel <= w_data;
		end
	end

	always @* begin
		next_rresp = `MIC_RESP_OKAY;
		next_rdata = 32'h0000_0000;
		if (S_AXI_ARADDR[`MIC_ADDR_HI] != 28'h000_0000 || S_AXI_ARADDR[1:0] != 2'b00)
			next_rresp = `MIC_RESP_SLVERR;
		else begin
			case (S_AXI_ARADDR[`MIC_ADDR_LO])
				`MIC_ADDR_SENSE:  next_rdata = {24'h00_0000, sense};
				`MIC_ADDR_PINSEL: next_rdata = {24'h00_0000, pinsel};
				`MIC_ADDR_STATUS: begin
					next_rdata[`MIC_STAT_MASK] = GLOBAL_MASK;
					next_rdata[`MIC_STAT_BUSY] = CPU_STALL;
					next_rdata[`MIC_STAT_WAKE] = WAKE_UP;
				end
				`MIC_ADDR_PEND:   next_rdata = {18'h0_0000, req_all};
				default:          next_rresp = `MIC_RESP_SLVERR;
			endcase
		end
	end

	always @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA  <= 32'h0000_0000;
			S_AXI_RRESP  <= `MIC_RESP_OKAY;
		end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
			S_AXI_RVALID <= 1'b1;
			S_AXI_RDATA  <= next_rdata;
			S_AXI_RRESP  <= next_rresp;
		end else if (S_AXI_RREADY) begin
			S_AXI_RVALID <= 1'b0;
		end
	end

endmodule // mic_intc

// ==== common/mic_consts.vh ====
// constants for the interrupt controller: register map, reset values,
// vector addresses, sense codes and sequencer states.
// assumes inclusion by bare name from the rtl files.
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

// ----------------------------------------
// register map (byte addresses)
// ----------------------------------------
`define MIC_ADDR_SENSE      4'h0
`define MIC_ADDR_PINSEL     4'h4
`define MIC_ADDR_STATUS     4'h8
`define MIC_ADDR_PEND       4'hC
`define MIC_ADDR_HI         31:4
`define MIC_ADDR_LO         3:0

// ----------------------------------------
// reset values and vector addresses
// ----------------------------------------
`define MIC_SENSE_RST       8'h00
`define MIC_PINSEL_RST      8'h0C
`define MIC_VEC_RESET       16'hFFFE
`define MIC_VEC_TRAP        16'hFFFC
`define MIC_VEC_SRC0        16'hFFFA

// ----------------------------------------
// sources and sense codes
// ----------------------------------------
`define MIC_NSRC            14
`define MIC_SRC_AWU         0
`define MIC_SRC_LINE0       1
`define MIC_SRC_ATOVF       9
`define MIC_SRC_LTRTC1      11
`define MIC_SRC_SPI         12
`define MIC_SENSE_FALL_LOW  2'b00
`define MIC_SENSE_RISE      2'b01
`define MIC_SENSE_FALL      2'b10
`define MIC_SENSE_BOTH      2'b11
`define MIC_PINSEL_PB4      2'b01

// ----------------------------------------
// bus responses and status bits
// ----------------------------------------
`define MIC_RESP_OKAY       2'b00
`define MIC_RESP_SLVERR     2'b10
`define MIC_STAT_MASK       0
`define MIC_STAT_BUSY       1
`define MIC_STAT_WAKE       2

// ----------------------------------------
// sequencer states
// ----------------------------------------
`define MIC_ST_IDLE         2'b00
`define MIC_ST_PUSH         2'b01
`define MIC_ST_LOAD         2'b10
`define MIC_ST_POP          2'b11
`define MIC_CTX_LAST        2'b11

`endif

// ==== verification/mic_intc_props.sv ====
// checker for the interrupt controller: entry, return, vectors, wake.
// assumes it is bound onto mic_intc and sees only its ports.
`timescale 1ns/1ps

module mic_intc_props (
	// clock and reset
	input wire        CLK,
	input wire        RST_N,
	// cpu sequencer
	input wire        INSTR_END,
	input wire        TRAP_EXEC,
	input wire        RETURN_FROM_HANDLER_EXEC,
	input wire        CPU_STALL,
	input wire        STACK_PUSH,
	input wire        STACK_POP,
	input wire [1:0]  STACK_SEL,
	input wire        PC_LOAD,
	input wire [15:0] VEC_ADDR,
	input wire        GLOBAL_MASK,
	// requests and modes
	input wire [13:0] PERIPH_FLAG,
	input wire [13:0] PERIPH_EN,
	input wire [13:0] PERIPH_CLR,
	input wire        MODE_WAIT,
	input wire        MODE_ACTIVE_HALT,
	input wire        WAKE_UP
);
	default clocking dc @(posedge CLK);
	endclocking
	default disable iff (!RST_N);

	property p_entry_push;
		STACK_PUSH && STACK_SEL == 2'b00 |=> STACK_PUSH && STACK_SEL == 2'b01 ##1 STACK_PUSH && STACK_SEL == 2'b10
			##1 STACK_PUSH && STACK_SEL == 2'b11 ##1 PC_LOAD && !STACK_PUSH ##1 GLOBAL_MASK;
	endproperty
	a_entry_push: assert property (p_entry_push) else $error("entry sequence broken");
	property p_masked_quiet;
		INSTR_END && GLOBAL_MASK && !TRAP_EXEC && !CPU_STALL |=> !STACK_PUSH;
	endproperty
	a_masked_quiet: assert property (p_masked_quiet) else $error("entry while masked");
	property p_return_pop;
		RETURN_FROM_HANDLER_EXEC && !CPU_STALL |=> STACK_POP && STACK_SEL == 2'b11 ##1 STACK_POP && STACK_SEL == 2'b10
			##1 STACK_POP && STACK_SEL == 2'b01 ##1 STACK_POP && STACK_SEL == 2'b00 ##[1:2] !GLOBAL_MASK;
	endproperty
	a_return_pop: assert property (p_return_pop) else $error("return sequence broken");
	property p_vec_legal;
		PC_LOAD |-> VEC_ADDR == 16'hFFFC || (!VEC_ADDR[0] && VEC_ADDR <= 16'hFFFA && VEC_ADDR >= 16'hFFE2);
	endproperty
	a_vec_legal: assert property (p_vec_legal) else $error("vector out of table");
	property p_no_nest;
		PC_LOAD |=> GLOBAL_MASK && !STACK_PUSH;
	endproperty
	a_no_nest: assert property (p_no_nest) else $error("handler not masked");
	property p_reset_mask;
		$rose(RST_N) |-> GLOBAL_MASK [*3];
	endproperty
	a_reset_mask: assert property (p_reset_mask) else $error("mask clear after reset");
	property p_wait_wake;
		MODE_WAIT && (PERIPH_FLAG & PERIPH_EN & 14'h1FE1) != 14'h0000 && PERIPH_CLR == 14'h0000
			|-> ##[1:4] (WAKE_UP || !MODE_WAIT);
	endproperty
	a_wait_wake: assert property (p_wait_wake) else $error("no wake from wait");
	property p_ahalt_wake;
		MODE_ACTIVE_HALT && !MODE_WAIT && PERIPH_FLAG[9] && PERIPH_EN[9] && !PERIPH_CLR[9]
			|-> ##[1:4] (WAKE_UP || !MODE_ACTIVE_HALT);
	endproperty
	a_ahalt_wake: assert property (p_ahalt_wake) else $error("no wake from active halt");

	c_trap: cover property (PC_LOAD && VEC_ADDR == 16'hFFFC);
	c_return: cover property (STACK_POP && STACK_SEL == 2'b00);
	c_wake: cover property ($rose(WAKE_UP));
endmodule // mic_intc_props

bind mic_intc mic_intc_props u_mic_intc_props (.*);

// ==== verification/mic_cpu_model.sv ====
// far-side model of the cpu sequencer: instruction ends, trap, return.
// assumes one-cycle request pulses from the bench.
`timescale 1ns/1ps

module mic_cpu_model (
	// clock and reset
	input  wire CLK,
	input  wire RST_N,
	// bench requests
	input  wire trap_req,
	input  wire return_from_handler_req,
	// core side
	input  wire CPU_STALL,
	output reg  INSTR_END,
	output reg  TRAP_EXEC,
	output reg  RETURN_FROM_HANDLER_EXEC
);
	reg  phase;
	reg  trap_due;
	reg  return_from_handler_due;
	wire ends    = phase & ~CPU_STALL;
	wire do_trap = trap_due | trap_req;
	wire do_return_from_handler = return_from_handler_due | return_from_handler_req;

	// one instruction end every other cycle, never while stalled,
	// so a trap or return is never offered to a busy sequencer
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			phase <= 1'b0;
			trap_due <= 1'b0;
			return_from_handler_due <= 1'b0;
			INSTR_END <= 1'b0;
			TRAP_EXEC <= 1'b0;
			RETURN_FROM_HANDLER_EXEC <= 1'b0;
		end else begin
			phase <= ~phase;
			INSTR_END <= ends;
			TRAP_EXEC <= ends & do_trap;
			RETURN_FROM_HANDLER_EXEC <= ends & do_return_from_handler & ~do_trap;
			trap_due <= do_trap & ~ends;
			return_from_handler_due <= do_return_from_handler & ~(ends & ~do_trap);
		end
	end
endmodule // mic_cpu_model

// ==== verification/test_mic_intc.sv ====
// testbench for the interrupt controller: bus tasks and scenarios.
// assumes mic_intc, mic_cpu_model and the bound checker.
`timescale 1ns/1ps

module test_mic_intc;
	logic        clk = 1'b0, rst_n = 1'b0;
	logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000, rdata;
	logic [3:0]  wstrb = 4'hF;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, wake, pc_load, stall, iend, texec, iexec;
	logic [1:0]  rresp;
	logic [13:0] flag = 14'h0000, en = 14'h0000, clr = 14'h0000;
	logic        set_mask = 1'b0, clr_mask = 1'b0, mode_wait = 1'b0, mode_ah = 1'b0;
	logic        trap_req = 1'b0, return_from_handler_req = 1'b0;
	logic [7:0]  pa = 8'hFF;
	logic [6:0]  pb = 7'h7F;
	logic [3:0]  nand_en = 4'h0;
	logic        mode_halt = 1'b0;
	logic [1:0]  bresp;
	logic [15:0] vec;
	int          bad_count = 0, total_checks = 0;

	always #20 clk = ~clk;

	mic_intc u_mic_intc (.CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .PORT_A(pa), .PORT_B(pb),
		.EXT_NAND_EN(nand_en), .PERIPH_FLAG(flag), .PERIPH_EN(en), .PERIPH_CLR(clr), .INSTR_END(iend),
		.TRAP_EXEC(texec), .RETURN_FROM_HANDLER_EXEC(iexec), .SET_MASK(set_mask), .CLR_MASK(clr_mask), .CPU_STALL(stall),
		.STACK_PUSH(), .STACK_POP(), .STACK_SEL(), .PC_LOAD(pc_load), .VEC_ADDR(vec), .GLOBAL_MASK(),
		.MODE_WAIT(mode_wait), .MODE_HALT(mode_halt), .MODE_AUTO_WAKEUP_HALT_MODE(1'b0), .MODE_ACTIVE_HALT(mode_ah),
		.WAKE_UP(wake));

	mic_cpu_model u_mic_cpu_model (.CLK(clk), .RST_N(rst_n), .trap_req(trap_req), .return_from_handler_req(return_from_handler_req),
		.CPU_STALL(stall), .INSTR_END(iend), .TRAP_EXEC(texec), .RETURN_FROM_HANDLER_EXEC(iexec));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic hang(input int n);
		if (n > 200) begin
			bad_count++;
			$display("wrong value at %0t: wait ran out", $time);
			print_verdict();
		end
	endtask

	// ready is sampled mid-cycle, where nothing is moving
	task automatic bus_write(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
		logic aw, w, b;
		int n;
		{aw, w, b, n} = {3'b110, 32'h0000_0000};
		// one edge first, so a back-to-back call never re-drives a strobe in one step
		@(posedge clk);
		awaddr <= 32'(a);
		wdata <= 32'(d);
		wstrb <= s;
		{awvalid, wvalid, bready} <= 3'b111;
		while (!b) begin
			@(negedge clk);
			aw = aw & !awready;
			w = w & !wready;
			b = bvalid;
			@(posedge clk);
			{awvalid, wvalid, bready} <= {aw, w, !b};
			n++;
			hang(n);
		end
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		logic ar, rv;
		int n;
		{ar, rv, n} = {2'b10, 32'h0000_0000};
		@(posedge clk);
		araddr <= 32'(a);
		{arvalid, rready} <= 2'b11;
		while (!rv) begin
			@(negedge clk);
			ar = ar & !arready;
			rv = rvalid;
			d = rdata;
			@(posedge clk);
			{arvalid, rready} <= {ar, !rv};
			n++;
			hang(n);
		end
	endtask

	task automatic cpu_req(input logic t);
		{trap_req, return_from_handler_req} <= {t, !t};
		@(posedge clk);
		{trap_req, return_from_handler_req} <= 2'b00;
	endtask

	task automatic clear_flag(input int b);
		clr[b] <= 1'b1;
		@(posedge clk);
		clr <= 14'h0000;
	endtask

	task automatic wait_vec(input logic [15:0] v);
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
			hang(n);
		end while (pc_load !== 1'b1);
		check(32'(vec), 32'(v));
		@(posedge clk);
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_reset_values;
		logic [31:0] d;
		bus_read(8'h00, d);
		check(d, 32'h0000_0000);
		bus_read(8'h04, d);
		check(d, 32'h0000_000C);
		bus_read(8'h08, d);
		check(32'(d[0]), 32'h0000_0001);
		bus_read(8'h10, d);
		check(32'(rresp), 32'h0000_0002);
		bus_write(8'h10, 8'h00, 4'hF);
		check(32'(bresp), 32'h0000_0002);
		bus_write(8'h00, 8'hE4, 4'hF);
		bus_read(8'h00, d);
		check(d, 32'h0000_00E4);
	endtask

	task automatic t_wake_pending;
		logic [31:0] d;
		{en, flag, mode_wait} <= {14'h0220, 14'h0220, 1'b1};
		bus_read(8'h0C, d);
		check(d, 32'h0000_0220);
		check(32'(wake), 32'h0000_0001);
		{mode_wait, mode_ah, flag} <= {2'b01, 14'h0200};
		bus_read(8'h08, d);
		check(32'(d[2]), 32'h0000_0001);
		{mode_ah, flag} <= {1'b0, 14'h0000};
	endtask

	task automatic t_entry_order;
		logic [31:0] d;
		cpu_req(1'b1);
		wait_vec(16'hFFFC);
		cpu_req(1'b0);
		wait_vec(16'hFFF0);
		clear_flag(5);
		cpu_req(1'b0);
		wait_vec(16'hFFE8);
		clear_flag(9);
		cpu_req(1'b0);
		bus_read(8'h0C, d);
		check(d, 32'h0000_0000);
		bus_read(8'h04, d);
		bus_read(8'h08, d);
		check(32'(d[0]), 32'h0000_0000);
	endtask

	task automatic t_masked_writes;
		logic [31:0] d;
		bus_write(8'h00, 8'h00, 4'hF);
		bus_read(8'h00, d);
		check(d, 32'h0000_00E4);
		flag[10] <= 1'b1;
		@(posedge clk);
		flag[10] <= 1'b0;
		clear_flag(10);
		en[10] <= 1'b1;
		bus_read(8'h0C, d);
		check(d, 32'h0000_0000);
		set_mask <= 1'b1;
		@(posedge clk);
		set_mask <= 1'b0;
		bus_write(8'h00, 8'h1B, 4'hF);
		bus_write(8'h00, 8'hFF, 4'h0);
		bus_read(8'h00, d);
		check(d, 32'h0000_001B);
		clr_mask <= 1'b1;
		@(posedge clk);
		clr_mask <= 1'b0;
		bus_read(8'h08, d);
		check(32'(d[0]), 32'h0000_0000);
	endtask

	task automatic t_ext_lines;
		logic [31:0] d;
		pa <= 8'hFE;
		wait_vec(16'hFFF8);
		bus_read(8'h0C, d);
		check(d, 32'h0000_0000);
		pa <= 8'hFF;
		bus_read(8'h0C, d);
		check(d, 32'h0000_0002);
		bus_write(8'h00, 8'h5A, 4'hF);
		bus_read(8'h0C, d);
		check(d, 32'h0000_0000);
		pb <= 7'h7E;
		bus_write(8'h00, 8'h1A, 4'hF);
		bus_read(8'h0C, d);
		check(d, 32'h0000_0010);
		{pa, nand_en} <= {8'h7F, 4'h2};
		bus_read(8'h0C, d);
		check(d, 32'h0000_0010);
		{pa, pb, nand_en} <= {8'hFF, 7'h7F, 4'h0};
		bus_read(8'h0C, d);
		check(d, 32'h0000_0000);
		{mode_halt, pb} <= {1'b1, 7'h7E};
		bus_read(8'h08, d);
		check(32'(d[2]), 32'h0000_0001);
		{mode_halt, pb} <= {1'b0, 7'h7F};
		cpu_req(1'b0);
		wait_vec(16'hFFF2);
		cpu_req(1'b0);
	endtask

	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset_values();
		t_wake_pending();
		t_entry_order();
		t_masked_writes();
		t_ext_lines();
		print_verdict();
	end
endmodule // test_mic_intc
